// ---- dcr_pkg.sv ----
// constants for the converter command register block
`default_nettype none
package dcr_pkg;
  localparam int          FRAME_BITS   = 24;
  localparam int          DATA_BITS    = 16;
  localparam int          CODE_BITS    = 12;
  localparam int          CHANNELS     = 4;
  // frame field positions
  localparam int          FRM_RW       = 23;
  localparam int          FRM_ADDR_HI  = 19;
  localparam int          FRM_ADDR_LO  = 16;
  localparam int          FRM_CODE_HI  = 15;
  localparam int          FRM_CODE_LO  = 4;
  // register addresses
  localparam logic [3:0]  ADDR_CMD     = 4'h0;
  localparam logic [3:0]  ADDR_DAC0    = 4'h4;
  localparam logic [3:0]  ADDR_DAC3    = 4'h7;
  // command register fields
  localparam int          CMD_READ_SEL = 15;
  localparam int          CMD_LOAD_ALL = 14;
  localparam int          CMD_SOFT_RST = 13;
  localparam int          CMD_PD_A     = 12;
  localparam int          CMD_PD_B     = 11;
  localparam int          CMD_RSVD     = 10;
  localparam int          CMD_GPIO1    = 9;
  localparam int          CMD_GPIO0    = 8;
  localparam int          CMD_SDO_OFF  = 7;
  localparam int          CMD_GAIN_HI  = 5;
  localparam int          CMD_GAIN_LO  = 2;
  localparam logic [15:0] CMD_RESET    = 16'h033C;
  // values after reset, and the last bit count
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [4:0]  CNT_RESET    = 5'h00;
  localparam logic [4:0]  CNT_LAST     = 5'h17;
  localparam logic [1:0]  GPIO_RESET   = 2'h3;
  localparam logic        PIN_IDLE     = 1'h1;
endpackage
`default_nettype wire

// ---- dcr_sync3.sv ----
// three-stage synchroniser, output moves once stages two and three agree
`default_nettype none
module dcr_sync3 #(
  parameter int               W         = 1,
  parameter logic [W-1:0]     RESET_VAL = '0
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           reset,
  // level in and out
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      q  <= RESET_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule
`default_nettype wire

// ---- dcr_command_upper.sv ----
// serial-link command register, data latches and pin control of a quad dac
`default_nettype none
module dcr_command_upper
  import dcr_pkg::*;
(
  // core clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // serial link
  input  wire logic                     link_sclk,
  input  wire logic                     link_cs_n,
  input  wire logic                     link_sdi,
  output logic                          link_sdo,
  output logic                          link_sdo_oe,
  // latch load pin
  input  wire logic                     latch_load_pin_n,
  // general-purpose open-drain pins
  input  wire logic [1:0]               gpio_in,
  output logic      [1:0]               gpio_out,
  output logic      [1:0]               gpio_oe,
  // channel state
  output logic [CHANNELS-1:0][CODE_BITS-1:0] dac_latch,
  output logic                          group_a_powerdown,
  output logic                          group_b_powerdown
);
  // ---------------- link domain ----------------
  // link-side capture of the incoming frame
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] next_shift_in;
  logic [4:0]            bit_cnt;
  logic [4:0]            next_bit_cnt;
  logic [FRAME_BITS-1:0] frame_word;
  logic [FRAME_BITS-1:0] next_frame_word;
  logic                  frame_tog;
  logic                  next_frame_tog;
  logic [FRAME_BITS-1:0] out_word;
  logic [DATA_BITS-1:0]  rd_word;
  logic                  sdo_off;

  // counter and shifter end with the frame's own select
  always_comb begin
    next_shift_in = {shift_in[FRAME_BITS-2:0], link_sdi};
    next_bit_cnt  = (bit_cnt == CNT_LAST) ? CNT_RESET : bit_cnt + 5'h01;
  end

  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      shift_in <= '0;
      bit_cnt  <= CNT_RESET;
    end else begin
      shift_in <= next_shift_in;
      bit_cnt  <= next_bit_cnt;
    end
  end

  // whole frame is held and announced by a toggle
  always_comb begin
    next_frame_word = frame_word;
    next_frame_tog  = frame_tog;
    if (!link_cs_n && bit_cnt == CNT_LAST) begin
      next_frame_word = next_shift_in;
      next_frame_tog  = ~frame_tog;
    end
  end

  always_ff @(posedge link_sclk or posedge reset) begin
    if (reset) begin
      frame_word <= '0;
      frame_tog  <= 1'b0;
    end else begin
      frame_word <= next_frame_word;
      frame_tog  <= next_frame_tog;
    end
  end

  // answer of the previous read frame, msb first
  assign out_word    = {8'h00, rd_word};
  assign link_sdo    = out_word[5'd23 - bit_cnt];
  assign link_sdo_oe = ~link_cs_n & ~sdo_off;

  // ---------------- core domain ----------------
  logic                  tog_sync;
  logic                  tog_seen;
  logic                  ld_pin;
  logic                  ld_pin_prev;
  logic [1:0]            gpio_lvl;
  logic                  frame_new;
  logic                  wr_cmd;
  logic                  wr_dac;
  logic                  rd_req;
  logic [3:0]            frm_addr;
  logic [1:0]            frm_chan;
  logic                  latch_update;
  logic                  soft_rst;
  logic                  next_soft_rst;
  logic                  rst_all;

  // stored command fields and channel storage
  logic                  read_sel;
  logic                  pd_a;
  logic                  pd_b;
  logic [1:0]            gpio_ctl;
  logic [3:0]            gain;
  logic [CHANNELS-1:0][CODE_BITS-1:0] din;
  logic [CHANNELS-1:0]   dirty;

  // next values
  logic [DATA_BITS-1:0]  next_rd_word;
  logic                  next_read_sel;
  logic                  next_pd_a;
  logic                  next_pd_b;
  logic [1:0]            next_gpio_ctl;
  logic [3:0]            next_gain;
  logic                  next_sdo_off;
  logic [CHANNELS-1:0][CODE_BITS-1:0] next_din;
  logic [CHANNELS-1:0][CODE_BITS-1:0] next_latch;
  logic [CHANNELS-1:0]   next_dirty;

  // register word as seen by the host
  function automatic logic [DATA_BITS-1:0] cmd_view(
    input logic       sel,
    input logic       pa,
    input logic       pb,
    input logic [1:0] lvl,
    input logic       off,
    input logic [3:0] g
  );
    logic [DATA_BITS-1:0] v;
    // fields not held here read 0
    v = '0;
    v[CMD_READ_SEL] = sel;
    v[CMD_PD_A]     = pa;
    v[CMD_PD_B]     = pb;
    v[CMD_GPIO1]    = lvl[1];
    v[CMD_GPIO0]    = lvl[0];
    v[CMD_SDO_OFF]  = off;
    v[CMD_GAIN_HI:CMD_GAIN_LO] = g;
    // load-all, reset and bit 10 always read 0
    return v;
  endfunction

  // data register addresses four through seven
  function automatic logic is_dac_addr(input logic [3:0] a);
    return (a >= ADDR_DAC0) && (a <= ADDR_DAC3);
  endfunction

  assign rst_all = reset | soft_rst;

  dcr_sync3 #(.W(1), .RESET_VAL(1'b0)) u_tog_sync (
    .clk   (core_clk),
    .reset (reset),
    .d     (frame_tog),
    .q     (tog_sync)
  );

  // pin inputs cross on three flops
  dcr_sync3 #(.W(3), .RESET_VAL({PIN_IDLE, GPIO_RESET})) u_pin_sync (
    .clk   (core_clk),
    .reset (reset),
    .d     ({latch_load_pin_n, gpio_in}),
    .q     ({ld_pin, gpio_lvl})
  );

  // frame word is stable for many core cycles after its toggle settles
  always_comb begin
    frame_new = tog_sync != tog_seen;
    frm_addr  = frame_word[FRM_ADDR_HI:FRM_ADDR_LO];
    frm_chan  = frm_addr[1:0];
    wr_cmd    = frame_new & ~frame_word[FRM_RW] & (frm_addr == ADDR_CMD);
    wr_dac    = frame_new & ~frame_word[FRM_RW] &
                is_dac_addr(frm_addr);
    rd_req    = frame_new & frame_word[FRM_RW];
    // pin falling edge, or load-all while pin is high
    latch_update = (ld_pin_prev & ~ld_pin) |
                   (wr_cmd & frame_word[CMD_LOAD_ALL] & ld_pin);
    next_soft_rst = wr_cmd & frame_word[CMD_SOFT_RST];
  end

  // command register, data registers and latches
  always_comb begin
    // hold by default
    next_read_sel = read_sel;
    next_pd_a     = pd_a;
    next_pd_b     = pd_b;
    next_gpio_ctl = gpio_ctl;
    next_gain     = gain;
    next_sdo_off  = sdo_off;
    next_din      = din;
    next_latch    = dac_latch;
    next_dirty    = dirty;
    next_rd_word  = rd_word;
    // writes accepted regardless of power-down
    if (wr_cmd) begin
      next_read_sel = frame_word[CMD_READ_SEL];
      next_pd_a     = frame_word[CMD_PD_A];
      next_pd_b     = frame_word[CMD_PD_B];
      next_gpio_ctl = frame_word[CMD_GPIO1:CMD_GPIO0];
      next_gain     = frame_word[CMD_GAIN_HI:CMD_GAIN_LO];
      next_sdo_off  = frame_word[CMD_SDO_OFF];
    end
    // reload only channels written since the last update
    if (latch_update) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (dirty[i]) begin
          next_latch[i] = din[i];
        end
      end
      next_dirty = '0;
    end
    // a write in the update cycle stays pending
    if (wr_dac) begin
      next_din[frm_chan]   = frame_word[FRM_CODE_HI:FRM_CODE_LO];
      next_dirty[frm_chan] = 1'b1;
    end
    // read answer captured at the request
    if (rd_req) begin
      next_rd_word = '0;
      if (frm_addr == ADDR_CMD) begin
        next_rd_word = cmd_view(read_sel, pd_a, pd_b, gpio_lvl,
                                sdo_off, gain);
      end else if (is_dac_addr(frm_addr)) begin
        next_rd_word[FRM_CODE_HI:FRM_CODE_LO] =
          read_sel ? dac_latch[frm_chan] : din[frm_chan];
      end
    end
  end

  // one-cycle pulse, starts once tog_seen catches up with the frame toggle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= next_soft_rst;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      // default command word
      read_sel  <= CMD_RESET[CMD_READ_SEL];
      pd_a      <= CMD_RESET[CMD_PD_A];
      pd_b      <= CMD_RESET[CMD_PD_B];
      gpio_ctl  <= CMD_RESET[CMD_GPIO1:CMD_GPIO0];
      gain      <= CMD_RESET[CMD_GAIN_HI:CMD_GAIN_LO];
      sdo_off   <= CMD_RESET[CMD_SDO_OFF];
      din       <= {CHANNELS{CODE_RESET}};
      dac_latch <= {CHANNELS{CODE_RESET}};
      dirty     <= '0;
      rd_word   <= '0;
    end else begin
      read_sel  <= next_read_sel;
      pd_a      <= next_pd_a;
      pd_b      <= next_pd_b;
      gpio_ctl  <= next_gpio_ctl;
      gain      <= next_gain;
      sdo_off   <= next_sdo_off;
      din       <= next_din;
      dac_latch <= next_latch;
      dirty     <= next_dirty;
      rd_word   <= next_rd_word;
    end
  end

  // frame tracking survives a software reset so no frame is replayed
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tog_seen    <= 1'b0;
      ld_pin_prev <= PIN_IDLE;
    end else begin
      tog_seen    <= tog_sync;
      ld_pin_prev <= ld_pin;
    end
  end

  // open-drain pins only ever pull low
  assign gpio_out          = 2'h0;
  assign gpio_oe           = ~gpio_ctl;
  // power-down levels straight from the command bits
  assign group_a_powerdown = pd_a;
  assign group_b_powerdown = pd_b;
endmodule
`default_nettype wire

// ---- dcr_command_upper_sva.sv ----
// port checks of the command register block
`default_nettype none
module dcr_command_upper_sva
  import dcr_pkg::*;
(
  // clock and reset
  input wire logic                               core_clk,
  input wire logic                               reset,
  // link and latch pin
  input wire logic                               link_cs_n,
  input wire logic                               link_sdo_oe,
  input wire logic                               latch_load_pin_n,
  // outputs
  input wire logic [1:0]                         gpio_out,
  input wire logic [1:0]                         gpio_oe,
  input wire logic [CHANNELS-1:0][CODE_BITS-1:0] dac_latch,
  input wire logic                               group_a_powerdown,
  input wire logic                               group_b_powerdown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_pins_low; gpio_out == 2'h0; endproperty
  a_pins_low: assert property (p_pins_low)
    else $error("open-drain level not low");
  property p_rst_pins; $fell(reset) |-> gpio_oe == 2'h0; endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not released after reset");
  property p_rst_pd;
    $fell(reset) |-> !group_a_powerdown && !group_b_powerdown;
  endproperty
  a_rst_pd: assert property (p_rst_pd)
    else $error("power-down set after reset");
  property p_rst_latch; $fell(reset) |-> dac_latch == '0; endproperty
  a_rst_latch: assert property (p_rst_latch)
    else $error("latches not cleared by reset");
  property p_sdo_idle; link_cs_n |-> !link_sdo_oe; endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial out driven outside frame");
  // pin low long enough that its falling edge has been served
  property p_pin_hold;
    (!latch_load_pin_n)[*8] |=> $stable(dac_latch) || dac_latch == '0;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("latch moved while load pin low");
  property p_pd_hold;
    link_cs_n[*8] |=> $stable(group_a_powerdown) && $stable(group_b_powerdown);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power-down moved without a frame");
  property p_oe_hold; link_cs_n[*8] |=> $stable(gpio_oe); endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin drive moved without a frame");
  c_pd_on: cover property ($rose(group_a_powerdown));
  c_latch: cover property ($changed(dac_latch));
  c_pin: cover property ($rose(gpio_oe[1]));
endmodule
bind dcr_command_upper dcr_command_upper_sva u_sva (
  .core_clk(core_clk), .reset(reset), .link_cs_n(link_cs_n),
  .link_sdo_oe(link_sdo_oe), .latch_load_pin_n(latch_load_pin_n),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .dac_latch(dac_latch),
  .group_a_powerdown(group_a_powerdown),
  .group_b_powerdown(group_b_powerdown)
);
`default_nettype wire

// ---- dcr_host.sv ----
// host model: serial master sending 24-bit frames
`default_nettype none
module dcr_host (
  // link pins
  output logic      link_sclk,
  output logic      link_cs_n,
  output logic      link_sdi,
  input  wire logic link_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_sdi  = 1'b0;
  end
  // clock runs only inside the frame; data line flips when idle
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    #13;
    for (int i = 23; i >= 0; i--) begin
      link_cs_n = 1'b0;
      link_sdi  = tx[i];
      #80;
      rx[i]     = link_sdo;
      link_sclk = 1'b1;
      #80;
      link_sclk = 1'b0;
    end
    #40;
    link_cs_n = 1'b1;
    link_sdi  = ~link_sdi;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- dcr_command_upper_bench.sv ----
// self-checking bench of the command register block
`default_nettype none
module dcr_command_upper_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcr_pkg::*;
  logic        core_clk, reset, link_sclk, link_cs_n, link_sdi;
  logic        link_sdo, link_sdo_oe, latch_load_pin_n;
  logic [1:0]  gpio_in, gpio_out, gpio_oe, ext_lvl;
  logic [47:0] dac_latch, obs;
  logic        group_a_powerdown, group_b_powerdown;
  logic        sdo_line;
  logic [47:0] exp_q[$];
  logic [23:0] rx;
  logic [11:0] code[4];
  logic [15:0] w;
  int          bad_count = 0;
  int          samples_checked = 0;
  event        got;
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
  // a released serial out shows no stale level
  assign sdo_line = link_sdo_oe ? link_sdo : ~link_sdo;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  dcr_command_upper u_dut (.core_clk(core_clk), .reset(reset),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_sdi(link_sdi),
    .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
    .latch_load_pin_n(latch_load_pin_n), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .dac_latch(dac_latch),
    .group_a_powerdown(group_a_powerdown),
    .group_b_powerdown(group_b_powerdown));
  dcr_host u_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
    .link_sdi(link_sdi), .link_sdo(sdo_line));
  function automatic logic [47:0] st();
    return {44'h0, gpio_oe, group_a_powerdown, group_b_powerdown};
  endfunction
  function automatic logic [47:0] lat();
    return {code[3], code[2], code[1], code[0]};
  endfunction
  task automatic note(input logic [47:0] e, input logic [47:0] a);
    exp_q.push_back(e);
    obs = a;
    ->got;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_host.frame({4'h0, a, d}, rx);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    u_host.frame({4'h8, a, 16'h0000}, rx);
    u_host.frame({4'h8, ADDR_CMD, 16'h0000}, rx);
    note({32'h0, e}, {24'h0, rx});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [47:0] e;
    forever begin
      @(got);
      e = exp_q.pop_front();
      samples_checked++;
      if (obs !== e) begin
        bad_count++;
        $display("mismatch at %0t exp %h got %h", $time, e, obs);
      end
    end
  end
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    latch_load_pin_n = 1'b1;
    ext_lvl = 2'h3;
    void'($urandom(49458));
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    note(48'h0, dac_latch);
    note(48'h0, st());
    rd(ADDR_CMD, CMD_RESET);
    rd(4'h1, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      w = i ? 16'h0A3C : 16'h153C;
      @(posedge core_clk);
      ext_lvl <= 2'($urandom);
      wr(ADDR_CMD, w);
      note({44'h0, ~w[9:8], w[12], w[11]}, st());
      rd(ADDR_CMD, (w & 16'hF8FF) | {6'h0, w[9:8] & ext_lvl, 8'h0});
    end
    @(posedge core_clk);
    ext_lvl <= 2'h3;
    wr(ADDR_CMD, CMD_RESET);
    for (int c = 0; c < 4; c++) begin
      code[c] = 12'($urandom);
      wr(ADDR_DAC0 + 4'(c), {code[c], 4'h0});
      rd(ADDR_DAC0 + 4'(c), {code[c], 4'h0});
    end
    note(48'h0, dac_latch);
    wr(ADDR_CMD, CMD_RESET | 16'h4000);
    note(lat(), dac_latch);
    rd(ADDR_CMD, CMD_RESET);
    wr(ADDR_CMD, CMD_RESET | 16'h8000);
    w = {12'($urandom), 4'h0};
    wr(ADDR_DAC0 + 4'h2, w);
    rd(ADDR_DAC0 + 4'h2, {code[2], 4'h0});
    wr(ADDR_CMD, CMD_RESET | 16'hC000);
    code[2] = w[15:4];
    note(lat(), dac_latch);
    rd(ADDR_DAC0 + 4'h2, w);
    @(posedge core_clk);
    latch_load_pin_n <= 1'b0;
    w = {12'($urandom), 4'h0};
    wr(ADDR_DAC0 + 4'h1, w);
    wr(ADDR_CMD, CMD_RESET | 16'h5000);
    note(lat(), dac_latch);
    @(posedge core_clk);
    latch_load_pin_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    latch_load_pin_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    code[1] = w[15:4];
    note(lat(), dac_latch);
    latch_load_pin_n <= 1'b1;
    wr(ADDR_CMD, 16'h2000);
    note(48'h0, dac_latch);
    note(48'h0, st());
    rd(ADDR_CMD, CMD_RESET);
    complete_run();
  end
endmodule
`default_nettype wire
